// >>> src/slprs_recov_cnt.v
// Stop-recovery counter, advanced by slow-clock ticks.
// Assumes ticks are one-cycle pulses synchronous to the core clock.
`timescale 1ns/1ps
`include "slprs_regs.vh"
module slprs_recov_cnt #(
	parameter LONG_COUNT = `SLPRS_LONG_RECOV,
	parameter SHORT_COUNT = `SLPRS_SHORT_RECOV,
	parameter CNT_W = `SLPRS_CNT_W
) (
	input wire clk, // Core clock
	input wire srst, // Synchronous reset, high
	input wire hold, // Keep count at zero
	input wire tick, // Slow-clock tick
	input wire short_sel, // Short recovery chosen
	output reg done // Period counted out
);
	reg [CNT_W-1:0] count;
	wire [CNT_W-1:0] target;

	assign target = short_sel ? SHORT_COUNT[CNT_W-1:0] : LONG_COUNT[CNT_W-1:0];

	always @(posedge clk) begin
		if (srst) begin
			count <= {CNT_W{1'b0}};
			done <= 1'b0;
		end else if (hold) begin
			count <= {CNT_W{1'b0}};
			done <= 1'b0;
		end else if (!done && tick) begin
			count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
			done <= (count + {{(CNT_W-1){1'b0}}, 1'b1}) == target;
		end
	end
endmodule // slprs_recov_cnt

// >>> src/slprs_regs.vh
// Constants for the low-power, break and reset-status unit.
// Assumes a 32-bit APB slave port with byte addresses; included by bare name.
// Overview of operation
// - Wait or stop execution pulses a request to clear the global interrupt mask.
// - Wait mode gates CPU clock off, peripheral clock keeps running.
// - Enabled interrupt in wait wakes CPU; stacking starts one cycle later.
// - Reset or break also ends wait mode.
// - Break arriving in wait or stop sets the break-wake flag.
// - Watchdog stays enabled and running in wait when its disable bit is zero.
// - Stop entry resets recovery counter and gates system clocks and oscillator.
// - Interrupt ends stop; stacking begins only after recovery time elapses.
// - Recovery is 4096 slow-clock ticks, or 32 when short recovery selected.
// - Counter held reset from stop until recovery begins, then times recovery.
// - Reset or break also ends stop mode.
// - Break-wake flag cleared by writing zero and by any reset.
// - Reading the reset-cause register clears all its flags.
// - Power-on reset sets power-on flag, clears all other cause flags.
// - Each reset cause sets its own dedicated flag.
// - Monitor-entry reset sets the monitor-entry flag.
// - In break, other modules' flags clearable only while clear-enable is one.
// - Two-step flag clears stay protected in break, clear normally afterwards.
`ifndef SLPRS_REGS_VH
`define SLPRS_REGS_VH

`define SLPRS_ADDR_W 8
`define SLPRS_OFS_BWS 8'h00
`define SLPRS_OFS_LRC 8'h04
`define SLPRS_OFS_BFCC 8'h08
`define SLPRS_OFS_LPS 8'h0C

`define SLPRS_BWS_FLAG 0
`define SLPRS_BFCC_ENABLE 0
`define SLPRS_BFCC_RST 1'b0

`define SLPRS_LRC_POR 7
`define SLPRS_LRC_PIN 6
`define SLPRS_LRC_WDOG 5
`define SLPRS_LRC_BADOP 4
`define SLPRS_LRC_BADADR 3
`define SLPRS_LRC_MON 2
`define SLPRS_LRC_BROWN 1
`define SLPRS_LRC_POR_VAL 8'h80

`define SLPRS_LONG_RECOV 4096
`define SLPRS_SHORT_RECOV 32
`define SLPRS_CNT_W 13

`endif

// >>> src/slprs_top.v
// Low-power mode control, break status and reset-cause recording.
// Assumes all inputs synchronous to CORE_CLK; SRST is the power-on reset.
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "slprs_regs.vh"
module slprs_top #(
	parameter LONG_COUNT = `SLPRS_LONG_RECOV,
	parameter SHORT_COUNT = `SLPRS_SHORT_RECOV
) (
	input wire CORE_CLK, // Bus clock, 20 MHz
	input wire SRST, // Power-on reset, synchronous, high
	input wire PSEL, // APB select
	input wire PENABLE, // APB access phase
	input wire PWRITE, // APB write
	input wire [7:0] PADDR, // APB byte address
	input wire [31:0] PWDATA, // APB write data
	output reg [31:0] PRDATA, // APB read data
	output reg PREADY, // APB ready
	output reg PSLVERR, // APB error on unmapped address
	input wire WAIT_EXEC, // CPU executes wait, pulse
	input wire STOP_EXEC, // CPU executes stop, pulse
	input wire IRQ_REQ, // Enabled module interrupt, level
	input wire BREAK_REQ, // Break interrupt, level
	input wire BREAK_STATE, // CPU is in break state
	input wire INTERNAL_SLOW_CLOCK_TICK, // Internal slow clock tick
	input wire SHORT_RECOVERY_SELECT, // Configuration bit
	input wire WATCHDOG_DISABLE, // Configuration bit
	input wire PIN_RST, // External pin reset, pulse
	input wire WDOG_RST, // Watchdog reset, pulse
	input wire BAD_OPCODE_RST, // Illegal opcode reset, pulse
	input wire BAD_FETCH_RST, // Illegal fetch address reset, pulse
	input wire MONITOR_RST, // Monitor entry reset, pulse
	input wire BROWNOUT_RST, // Low-voltage reset, pulse
	output reg CPU_CLK_EN, // CPU clock gate
	output reg PERIPH_CLK_EN, // Peripheral clock gate
	output reg OSC_EN, // Oscillator output gate
	output reg IMASK_CLEAR, // Clear interrupt mask, pulse
	output reg STACK_START, // Begin stacking, pulse
	output reg STACK_BREAK, // Stacking is for break
	output reg WDOG_RUN, // Watchdog enabled and clocked
	output reg FLAG_CLEAR_ALLOW // Other modules may clear flags
);
	localparam [3:0] ST_RUN = 4'h1;
	localparam [3:0] ST_WAIT = 4'h2;
	localparam [3:0] ST_STOP = 4'h4;
	localparam [3:0] ST_RECOV = 4'h8;

	reg [3:0] state;
	reg [3:0] next_state;
	reg stack_pend;
	reg stack_brk;
	reg next_stack_pend;
	reg next_stack_brk;
	reg break_wake_flag;
	reg break_clear_enable;
	reg [7:0] last_reset_cause;
	wire rst_event;
	wire wake;
	wire recov_done;
	wire cnt_hold;
	wire apb_done;
	wire apb_wr;
	wire apb_rd;
	wire lrc_read;
	wire [7:0] cause_bits;
	reg [31:0] rd_mux;
	reg rd_err;

	assign rst_event = PIN_RST | WDOG_RST | BAD_OPCODE_RST | BAD_FETCH_RST | MONITOR_RST | BROWNOUT_RST;
	assign wake = IRQ_REQ | BREAK_REQ;
	assign apb_done = PSEL & PENABLE & PREADY;
	assign apb_wr = apb_done & PWRITE;
	assign apb_rd = apb_done & ~PWRITE;
	assign lrc_read = apb_rd && (PADDR == `SLPRS_OFS_LRC);
	// Counter sits at zero everywhere except recovery
	assign cnt_hold = (state != ST_RECOV);

	// Last reset only: each event replaces the whole picture
	assign cause_bits = {1'b0,
		PIN_RST, WDOG_RST, BAD_OPCODE_RST, BAD_FETCH_RST, MONITOR_RST, BROWNOUT_RST, 1'b0};

	slprs_recov_cnt #(
		.LONG_COUNT(LONG_COUNT),
		.SHORT_COUNT(SHORT_COUNT),
		.CNT_W(`SLPRS_CNT_W)
	) u_recov (
		.clk(CORE_CLK),
		.srst(SRST),
		.hold(cnt_hold),
		.tick(INTERNAL_SLOW_CLOCK_TICK),
		.short_sel(SHORT_RECOVERY_SELECT),
		.done(recov_done)
	);

	always @* begin
		next_state = state;
		next_stack_pend = 1'b0;
		next_stack_brk = stack_brk;
		case (state)
			ST_RUN: begin
				if (rst_event) begin
					next_state = ST_RUN;
				end else if (WAIT_EXEC) begin
					next_state = ST_WAIT;
				end else if (STOP_EXEC) begin
					next_state = ST_STOP;
				end
			end
			ST_WAIT: begin
				if (rst_event) begin
					next_state = ST_RUN;
				end else if (wake) begin
					// Clock back first, stacking on the following cycle
					next_state = ST_RUN;
					next_stack_pend = 1'b1;
					next_stack_brk = BREAK_REQ;
				end
			end
			ST_STOP: begin
				if (rst_event) begin
					next_state = ST_RUN;
				end else if (wake) begin
					next_state = ST_RECOV;
					next_stack_brk = BREAK_REQ;
				end
			end
			ST_RECOV: begin
				if (rst_event) begin
					next_state = ST_RUN;
				end else if (recov_done) begin
					next_state = ST_RUN;
					next_stack_pend = 1'b1;
				end
			end
			default: begin
				next_state = ST_RUN;
			end
		endcase
	end

	always @(posedge CORE_CLK) begin
		if (SRST) begin
			state <= ST_RUN;
			stack_pend <= 1'b0;
			stack_brk <= 1'b0;
			CPU_CLK_EN <= 1'b1;
			PERIPH_CLK_EN <= 1'b1;
			OSC_EN <= 1'b1;
			IMASK_CLEAR <= 1'b0;
			STACK_START <= 1'b0;
			STACK_BREAK <= 1'b0;
			WDOG_RUN <= 1'b0;
		end else begin
			state <= next_state;
			stack_pend <= next_stack_pend;
			stack_brk <= next_stack_brk;
			// CPU clock runs only in run state, ahead of the stacking pulse
			CPU_CLK_EN <= (next_state == ST_RUN);
			// Peripherals keep running through wait, stopped through stop and its recovery
			PERIPH_CLK_EN <= (next_state == ST_RUN) || (next_state == ST_WAIT);
			// Oscillator restarts for recovery so it can settle before CPU runs
			OSC_EN <= (next_state != ST_STOP);
			IMASK_CLEAR <= (state == ST_RUN) && !rst_event && (WAIT_EXEC || STOP_EXEC);
			STACK_START <= stack_pend;
			STACK_BREAK <= stack_pend & stack_brk;
			// Stop halts the watchdog clock with the system clocks
			WDOG_RUN <= !WATCHDOG_DISABLE && (next_state != ST_STOP);
		end
	end

	always @(posedge CORE_CLK) begin
		if (SRST) begin
			break_wake_flag <= 1'b0;
		end else if (rst_event) begin
			break_wake_flag <= 1'b0;
		end else if (BREAK_REQ && ((state == ST_WAIT) || (state == ST_STOP) || (state == ST_RECOV))) begin
			break_wake_flag <= 1'b1;
		end else if (apb_wr && (PADDR == `SLPRS_OFS_BWS) && !PWDATA[`SLPRS_BWS_FLAG]) begin
			break_wake_flag <= 1'b0;
		end
	end

	// A reset event in the same cycle as the read wins over the clear
	always @(posedge CORE_CLK) begin
		if (SRST) begin
			last_reset_cause <= `SLPRS_LRC_POR_VAL;
		end else if (rst_event) begin
			last_reset_cause <= cause_bits;
		end else if (lrc_read) begin
			last_reset_cause <= 8'h00;
		end
	end

	always @(posedge CORE_CLK) begin
		if (SRST) begin
			break_clear_enable <= `SLPRS_BFCC_RST;
		end else if (apb_wr && (PADDR == `SLPRS_OFS_BFCC)) begin
			break_clear_enable <= PWDATA[`SLPRS_BFCC_ENABLE];
		end
	end

	// Level gate: a first step taken before break cannot complete inside it,
	// and the second step after break sees the gate open again
	always @(posedge CORE_CLK) begin
		if (SRST) begin
			FLAG_CLEAR_ALLOW <= 1'b1;
		end else begin
			FLAG_CLEAR_ALLOW <= !BREAK_STATE || break_clear_enable;
		end
	end

	always @* begin
		rd_mux = 32'h00000000;
		rd_err = 1'b0;
		case (PADDR)
			`SLPRS_OFS_BWS: rd_mux[`SLPRS_BWS_FLAG] = break_wake_flag;
			`SLPRS_OFS_LRC: rd_mux[7:0] = last_reset_cause;
			`SLPRS_OFS_BFCC: rd_mux[`SLPRS_BFCC_ENABLE] = break_clear_enable;
			`SLPRS_OFS_LPS: rd_mux[3:0] = state;
			default: rd_err = 1'b1;
		endcase
	end

	// One wait state: PREADY rises in the second access cycle
	always @(posedge CORE_CLK) begin
		if (SRST) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h00000000;
		end else if (PSEL && PENABLE && !PREADY) begin
			PREADY <= 1'b1;
			PSLVERR <= rd_err;
			PRDATA <= PWRITE ? 32'h00000000 : rd_mux;
		end else begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h00000000;
		end
	end
endmodule // slprs_top

// >>> testbench/slprs_cpu_model.sv
// CPU-side model: executes wait or stop on command and makes the slow clock tick.
// Assumes commands come from the bench as one-cycle pulses on the core clock.
`timescale 1ns/1ps
module slprs_cpu_model (
	input wire clk, // Core clock
	input wire srst, // Reset, high
	input wire cmd_wait, // Bench asks for wait
	input wire cmd_stop, // Bench asks for stop
	input wire cpu_clk_en, // CPU clock gate
	output reg wait_exec, // Wait executed
	output reg stop_exec, // Stop executed
	output reg internal_slow_clock_tick // Slow clock tick
);
	reg [1:0] div;
	always @(posedge clk) begin
		if (srst) begin
			div <= 2'h0;
			wait_exec <= 1'h0;
			stop_exec <= 1'h0;
			internal_slow_clock_tick <= 1'h0;
		end else begin
			div <= div + 2'h1;
			// Ticks spaced four cycles apart so recovery ends between ticks
			internal_slow_clock_tick <= (div == 2'h3);
			// A CPU whose clock is gated cannot execute anything
			wait_exec <= cmd_wait & cpu_clk_en;
			stop_exec <= cmd_stop & cpu_clk_en;
		end
	end
endmodule // slprs_cpu_model

// >>> testbench/slprs_top_assertions.sv
// Checker for the low-power unit, bound to the top module.
// Assumes INTERNAL_SLOW_CLOCK_TICK pulses are at least three cycles apart.
`timescale 1ns/1ps
module slprs_chk #(parameter LONG_COUNT = 8, parameter SHORT_COUNT = 4) (
	input wire CORE_CLK, input wire SRST, input wire WAIT_EXEC, input wire STOP_EXEC, // Clock, reset, entry
	input wire IRQ_REQ, input wire BREAK_REQ, input wire BREAK_STATE, input wire INTERNAL_SLOW_CLOCK_TICK, // Wake and break
	input wire SHORT_RECOVERY_SELECT, input wire WATCHDOG_DISABLE, input wire PIN_RST, // Config, pin
	input wire WDOG_RST, input wire BAD_OPCODE_RST, input wire BAD_FETCH_RST, input wire MONITOR_RST, // Causes
	input wire BROWNOUT_RST, input wire CPU_CLK_EN, input wire PERIPH_CLK_EN, input wire OSC_EN, // Gates
	input wire IMASK_CLEAR, input wire STACK_START, input wire STACK_BREAK, input wire WDOG_RUN, // Events
	input wire FLAG_CLEAR_ALLOW // Flag gate
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SRST);
	wire any_rst = PIN_RST | WDOG_RST | BAD_OPCODE_RST | BAD_FETCH_RST | MONITOR_RST | BROWNOUT_RST;
	reg [12:0] ticks;
	// Only ticks seen in recovery count, as the unit's counter is held during stop
	always @(posedge CORE_CLK) begin
		if (SRST || PERIPH_CLK_EN)
			ticks <= 13'h0;
		else if (OSC_EN && INTERNAL_SLOW_CLOCK_TICK)
			ticks <= ticks + 13'h1;
	end
	imask_cause_a: assert property (IMASK_CLEAR |-> $past(WAIT_EXEC | STOP_EXEC))
		else $error("mask clear without entry");
	wait_gate_a: assert property (IMASK_CLEAR && $past(WAIT_EXEC) |-> !CPU_CLK_EN && PERIPH_CLK_EN)
		else $error("wait gating wrong");
	stop_gate_a: assert property (IMASK_CLEAR && $past(STOP_EXEC) |-> !CPU_CLK_EN && !PERIPH_CLK_EN && !OSC_EN)
		else $error("stop gating wrong");
	osc_wake_a: assert property (!OSC_EN && (IRQ_REQ || BREAK_REQ) |=> OSC_EN)
		else $error("stop not left");
	wake_order_a: assert property ($rose(CPU_CLK_EN) && !$past(any_rst) |=> STACK_START)
		else $error("stacking not one cycle after clock");
	stack_clk_a: assert property (STACK_START |-> CPU_CLK_EN && $past(CPU_CLK_EN))
		else $error("stacking without CPU clock");
	recov_len_a: assert property ($rose(PERIPH_CLK_EN) && !$past(any_rst) |->
		ticks == (SHORT_RECOVERY_SELECT ? SHORT_COUNT : LONG_COUNT))
		else $error("recovery length wrong");
	wdog_run_a: assert property (PERIPH_CLK_EN && $past(PERIPH_CLK_EN) && !$past(SRST) |->
		WDOG_RUN == !$past(WATCHDOG_DISABLE))
		else $error("watchdog run wrong");
	clear_allow_a: assert property (!$past(BREAK_STATE) |-> FLAG_CLEAR_ALLOW)
		else $error("flags blocked outside break");
	cover property ($rose(PERIPH_CLK_EN));
	cover property (STACK_START && STACK_BREAK);
	cover property (!FLAG_CLEAR_ALLOW);
endmodule // slprs_chk
bind slprs_top slprs_chk #(.LONG_COUNT(LONG_COUNT), .SHORT_COUNT(SHORT_COUNT)) i_chk (.*);

// >>> testbench/slprs_top_bench.sv
// Self-checking bench for the low-power, break and reset-status unit.
// Assumes the CPU model on the far side and the bound checker.
`timescale 1ns/1ps
module slprs_top_bench;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} slprs_row_t;
	logic CORE_CLK = 1'h0, SRST = 1'h1, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0, cmd_wait = 1'h0, cmd_stop = 1'h0;
	logic IRQ_REQ = 1'h0, BREAK_REQ = 1'h0, BREAK_STATE = 1'h0, SHORT_RECOVERY_SELECT = 1'h0, WATCHDOG_DISABLE = 1'h0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0, r;
	logic [5:0] rst_cause = 6'h00;
	logic e;
	wire [31:0] PRDATA;
	wire PREADY, PSLVERR, WAIT_EXEC, STOP_EXEC, INTERNAL_SLOW_CLOCK_TICK, CPU_CLK_EN, PERIPH_CLK_EN, OSC_EN;
	wire IMASK_CLEAR, STACK_START, STACK_BREAK, WDOG_RUN, FLAG_CLEAR_ALLOW;
	wire PIN_RST = rst_cause[5], WDOG_RST = rst_cause[4], BAD_OPCODE_RST = rst_cause[3];
	wire BAD_FETCH_RST = rst_cause[2], MONITOR_RST = rst_cause[1], BROWNOUT_RST = rst_cause[0];
	int err_total = 0, checked = 0;
	slprs_row_t rows [10] = '{'{0, 8'h04, 0, 32'h80, 0}, '{0, 8'h04, 0, 0, 0}, '{0, 8'h00, 0, 0, 0},
		'{1, 8'h04, 32'hFF, 0, 0}, '{0, 8'h04, 0, 0, 0}, '{1, 8'h08, 1, 0, 0}, '{0, 8'h08, 0, 1, 0},
		'{0, 8'h0C, 0, 1, 0}, '{0, 8'h10, 0, 0, 1}, '{1, 8'h10, 1, 0, 1}};
	slprs_top #(.LONG_COUNT(8), .SHORT_COUNT(4)) i_dut (.*);
	slprs_cpu_model i_cpu (.clk(CORE_CLK), .srst(SRST), .cmd_wait(cmd_wait), .cmd_stop(cmd_stop),
		.cpu_clk_en(CPU_CLK_EN), .wait_exec(WAIT_EXEC), .stop_exec(STOP_EXEC), .internal_slow_clock_tick(INTERNAL_SLOW_CLOCK_TICK));
	initial forever #25 CORE_CLK = ~CORE_CLK;
	task results;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge CORE_CLK);
	endtask
	// Entered just after an edge; holds the request until PREADY is sampled
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		PSEL <= 1'h1; PWRITE <= w; PADDR <= a; PWDATA <= d;
		@(posedge CORE_CLK);
		PENABLE <= 1'h1;
		do begin @(posedge CORE_CLK); n++; end while (PREADY !== 1'h1 && n < 50);
		if (PREADY !== 1'h1) err_total++;
		r = PRDATA;
		e = PSLVERR;
		PSEL <= 1'h0; PENABLE <= 1'h0;
		// One idle edge so the next call never reassigns PSEL in this step
		@(posedge CORE_CLK);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] x);
		apb(1'h0, a, 32'h0);
		check("rdata", r, x);
	endtask
	task lowpow(input logic stop, input logic brk);
		int n;
		cmd_wait <= !stop; cmd_stop <= stop;
		cyc(1);
		cmd_wait <= 1'h0; cmd_stop <= 1'h0;
		cyc(3);
		check("cpu_clk", CPU_CLK_EN, 1'h0);
		check("periph_clk", PERIPH_CLK_EN, !stop);
		check("osc", OSC_EN, !stop);
		check("wdog", WDOG_RUN, !stop);
		IRQ_REQ <= !brk; BREAK_REQ <= brk;
		for (n = 0; n < 300 && STACK_START !== 1'h1; n++) @(posedge CORE_CLK);
		check("stack_start", STACK_START, 1'h1);
		check("stack_break", STACK_BREAK, brk);
		IRQ_REQ <= 1'h0; BREAK_REQ <= 1'h0;
		cyc(2);
	endtask
	initial begin
		cyc(20);
		SRST <= 1'h0;
		cyc(1);
		WATCHDOG_DISABLE <= 1'h1;
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) check("row_rdata", r, rows[i].x);
			check("row_slverr", e, rows[i].e);
		end
		WATCHDOG_DISABLE <= 1'h0;
		apb(1'h1, 8'h08, 32'h0);
		for (int i = 0; i < 6; i++) begin
			rst_cause <= 6'h01 << i;
			cyc(1);
			rst_cause <= 6'h00;
			cyc(1);
			rdc(8'h04, 32'h2 << i);
		end
		lowpow(1'h0, 1'h0);
		// Full recovery with the short select cleared
		lowpow(1'h1, 1'h0);
		SHORT_RECOVERY_SELECT <= 1'h1;
		lowpow(1'h1, 1'h1);
		SHORT_RECOVERY_SELECT <= 1'h0;
		rdc(8'h00, 32'h1);
		apb(1'h1, 8'h00, 32'h1);
		rdc(8'h00, 32'h1);
		apb(1'h1, 8'h00, 32'h0);
		rdc(8'h00, 32'h0);
		lowpow(1'h0, 1'h1);
		rst_cause <= 6'h20;
		cyc(1);
		rst_cause <= 6'h00;
		cyc(1);
		rdc(8'h00, 32'h0);
		rdc(8'h04, 32'h40);
		BREAK_STATE <= 1'h1;
		cyc(3);
		check("allow", FLAG_CLEAR_ALLOW, 1'h0);
		apb(1'h1, 8'h08, 32'h1);
		cyc(2);
		check("allow", FLAG_CLEAR_ALLOW, 1'h1);
		BREAK_STATE <= 1'h0;
		SRST <= 1'h1;
		cyc(2);
		SRST <= 1'h0;
		cyc(1);
		rdc(8'h04, 32'h80);
		rdc(8'h08, 32'h0);
		results;
	end
	initial begin
		cyc(20000);
		err_total++;
		results;
	end
endmodule // slprs_top_bench
